// File: logic/twe_device.sv
// Memory device end of the two-wire port with page buffer and write cycle
// Contract
// - Byte write: address, word, data, stop
// - Ignore bus during internal write cycle
// - No acknowledge for protected block write
// - Page write bumps only low four bits
// - Extra page bytes overwrite wrapped locations
// - Early or mid-byte stop skips write
// - No acknowledge while write cycle busy
// - Address lsb one reads, zero writes
// - Counter holds last read plus one
// - Current read: ack, eight bits, nack
// - Master ends read via ninth clock
// - Random read: dummy write then restart
// - Stop after word sets current address
// - Master ack continues sequential read
// - Read counter wraps whole array
// - Slave byte: type, zeros, bit, direction
// - Registers at 1ff and 0ff
// - Standby, input, write latch cleared
// - Reset output held for delay
// - Acknowledge all bytes except bad address, refused write data and any byte during a write cycle
// - Second register data byte aborts, nack
// - Protect pin refuses all writes
`default_nettype none
module twe_device #(
  parameter int WR_CYC   = twe_pkg::WR_CYCLE_CYC,
  parameter int POR_STEP = twe_pkg::POR_STEP_CYC
)(
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  twe_bus_if.device       bus,
  input  wire logic       wp,
  output logic            rst_out_n,
  output logic            busy,
  output logic [7:0]      ctrl,
  output logic [7:0]      fault
);
  // ****************************************
  // Pin synchronisers and bus events
  // ****************************************
  logic [1:0] scl_y;
  logic [1:0] sda_y;
  logic [1:0] wp_y;
  logic       scl_d;
  logic       sda_d;
  logic       scl_s;
  logic       sda_s;
  logic       wp_s;

  // Two flops per pin, then one delay for edges
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
    begin
      scl_y <= 2'h3;
      sda_y <= 2'h3;
      wp_y  <= 2'h0;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_y <= {scl_y[0], bus.scl};
      sda_y <= {sda_y[0], bus.sda};
      wp_y  <= {wp_y[0], wp};
      scl_d <= scl_s;
      sda_d <= sda_s;
    end

  assign scl_s = scl_y[1];
  assign sda_s = sda_y[1];
  assign wp_s  = wp_y[1];

  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start    = scl_s & scl_d & sda_d & ~sda_s;
  assign stop     = scl_s & scl_d & ~sda_d & sda_s;

  // ****************************************
  // Protocol state and decisions
  // ****************************************
  twe_pkg::twe_dst_t  st;
  twe_pkg::twe_kind_t kind;
  logic [3:0]  bitcnt;
  logic [7:0]  sh;
  logic [7:0]  txsh;
  logic        rd_mode;
  logic        reg_acc;
  logic        sel_hi;
  logic        reg_ok;
  logic        mack;
  logic [8:0]  addr;
  logic [15:0] pmask;
  logic        reg_pend;
  logic        reg_cnt;
  logic [7:0]  reg_val;
  logic [7:0]  pbuf [twe_pkg::PAGE_BYTES];
  logic [7:0]  mem [twe_pkg::MEM_BYTES];
  logic [7:0]  rdat;
  logic        sda_oe_n;

  logic live;
  logic byte_end;
  logic slv_ok;
  logic mem_wr_ok;
  logic buf_we;
  logic commit;

  assign live      = ~busy & ~start & ~stop;
  assign byte_end  = live && st == twe_pkg::D_RX && scl_fall && bitcnt == 4'h8;
  assign slv_ok    = (sh[7:4] == twe_pkg::TYPE_MEM || sh[7:4] == twe_pkg::TYPE_REG)
                     && sh[3:2] == 2'h0;
  assign mem_wr_ok = ~wp_s & ctrl[twe_pkg::CTRL_WEL]
                     & ~(ctrl[twe_pkg::CTRL_BP] & addr[8]);
  assign buf_we    = byte_end && kind == twe_pkg::K_DATA && !reg_acc && mem_wr_ok;
  // Stop only counts after a full data byte and its acknowledge;
  // the stop's own clock high has already counted one rise
  assign commit    = stop && !busy && st == twe_pkg::D_RX && kind == twe_pkg::K_DATA
                     && bitcnt <= 4'h1 && !rd_mode;
  // Read source: array at counter or selected register
  assign rdat = reg_acc ? (sel_hi ? ctrl : fault) : mem[addr];

  assign bus.sda_d_out  = 1'b0;
  assign bus.sda_d_oe_n = sda_oe_n;

  // Bus sequencing, acknowledge and transmit
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
    begin
      st       <= twe_pkg::D_IDLE;
      kind     <= twe_pkg::K_SLV;
      bitcnt   <= 4'h0;
      sh       <= 8'h00;
      txsh     <= 8'h00;
      rd_mode  <= 1'b0;
      reg_acc  <= 1'b0;
      sel_hi   <= 1'b0;
      reg_ok   <= 1'b0;
      mack     <= 1'b0;
      addr     <= 9'h000;
      pmask    <= 16'h0000;
      reg_pend <= 1'b0;
      reg_cnt  <= 1'b0;
      reg_val  <= 8'h00;
      sda_oe_n <= 1'b1;
    end
    else if (busy)
    begin
      st       <= twe_pkg::D_IDLE;
      sda_oe_n <= 1'b1;
    end
    else if (start)
    begin
      st       <= twe_pkg::D_RX;
      kind     <= twe_pkg::K_SLV;
      bitcnt   <= 4'h0;
      sda_oe_n <= 1'b1;
    end
    else if (stop)
    begin
      st       <= twe_pkg::D_IDLE;
      sda_oe_n <= 1'b1;
    end
    else
      case (st)
        twe_pkg::D_RX:
        begin
          if (scl_rise)
          begin
            sh     <= {sh[6:0], sda_s};
            bitcnt <= bitcnt + 4'h1;
          end
          if (byte_end)
          begin
            bitcnt <= 4'h0;
            st     <= twe_pkg::D_ACK;
            case (kind)
              twe_pkg::K_SLV:
              begin
                reg_acc  <= sh[7:4] == twe_pkg::TYPE_REG;
                sel_hi   <= sh[1];
                rd_mode  <= sh[0];
                pmask    <= 16'h0000;
                reg_pend <= 1'b0;
                reg_cnt  <= 1'b0;
                kind     <= twe_pkg::K_WORD;
                sda_oe_n <= ~slv_ok;
                if (!slv_ok)
                  st <= twe_pkg::D_IDLE;
              end
              twe_pkg::K_WORD:
              begin
                if (!reg_acc)
                  addr <= {sel_hi, sh};
                reg_ok   <= sh == twe_pkg::REG_WORD;
                kind     <= twe_pkg::K_DATA;
                sda_oe_n <= 1'b0;
              end
              default:
              begin
                if (reg_acc)
                begin
                  if (reg_cnt)
                  begin
                    reg_pend <= 1'b0;
                    st       <= twe_pkg::D_IDLE;
                  end
                  else if (wp_s || !reg_ok)
                    st <= twe_pkg::D_IDLE;
                  else
                  begin
                    reg_pend <= 1'b1;
                    reg_cnt  <= 1'b1;
                    reg_val  <= sh;
                    sda_oe_n <= 1'b0;
                  end
                end
                else if (mem_wr_ok)
                begin
                  pmask[addr[3:0]] <= 1'b1;
                  addr[3:0]        <= addr[3:0] + 4'h1;
                  sda_oe_n         <= 1'b0;
                end
                else
                  st <= twe_pkg::D_IDLE;
              end
            endcase
          end
        end
        twe_pkg::D_ACK:
          if (scl_fall)
          begin
            bitcnt <= 4'h0;
            if (rd_mode)
            begin
              st       <= twe_pkg::D_TX;
              txsh     <= rdat;
              sda_oe_n <= rdat[7];
              if (!reg_acc)
                addr <= addr + 9'h001;
            end
            else
            begin
              st       <= twe_pkg::D_RX;
              sda_oe_n <= 1'b1;
            end
          end
        twe_pkg::D_TX:
          if (scl_fall)
          begin
            bitcnt <= bitcnt + 4'h1;
            txsh   <= {txsh[6:0], 1'b0};
            if (bitcnt == 4'h7)
            begin
              st       <= twe_pkg::D_MACK;
              sda_oe_n <= 1'b1;
            end
            else
              sda_oe_n <= txsh[6];
          end
        twe_pkg::D_MACK:
        begin
          if (scl_rise)
            mack <= ~sda_s;
          if (scl_fall)
          begin
            bitcnt <= 4'h0;
            if (mack)
            begin
              st       <= twe_pkg::D_TX;
              txsh     <= rdat;
              sda_oe_n <= rdat[7];
              if (!reg_acc)
                addr <= addr + 9'h001;
            end
            else
              st <= twe_pkg::D_IDLE;
          end
        end
        default:
          st <= twe_pkg::D_IDLE;
      endcase

  // ****************************************
  // Page buffer, array and write cycle
  // ****************************************
  logic [4:0]  cp;
  logic [31:0] tmr;

  // Page buffer load at the wrapped location
  always_ff @(posedge clk_sys)
    if (buf_we)
      pbuf[addr[3:0]] <= sh;

  // Copy loaded bytes into the page during the cycle
  always_ff @(posedge clk_sys)
    if (busy && !cp[4] && pmask[cp[3:0]])
      mem[{addr[8:4], cp[3:0]}] <= pbuf[cp[3:0]];

  // Self-timed write cycle
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
    begin
      busy <= 1'b0;
      cp   <= 5'h00;
      tmr  <= 32'h0;
    end
    else if (commit && pmask != 16'h0000)
    begin
      busy <= 1'b1;
      cp   <= 5'h00;
      tmr  <= 32'h0;
    end
    else if (busy)
    begin
      if (!cp[4])
        cp <= cp + 5'h01;
      tmr <= tmr + 32'h1;
      if (tmr == 32'(WR_CYC - 1))
        busy <= 1'b0;
    end

  // Volatile register update on a valid stop
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
    begin
      ctrl  <= twe_pkg::CTRL_RESET;
      fault <= twe_pkg::FAULT_RESET;
    end
    else if (commit && reg_pend)
    begin
      if (sel_hi)
        ctrl <= reg_val;
      else
        fault <= reg_val;
    end

  // ****************************************
  // Power-on reset output
  // ****************************************
  logic [31:0] por_cnt;
  logic [31:0] por_lim;

  // Delay steps 1, 4, 8, 16 from the two delay bits
  function automatic logic [31:0] por_steps(input logic [1:0] sel);
    case (sel)
      2'h0:    por_steps = 32'h1;
      2'h1:    por_steps = 32'h4;
      2'h2:    por_steps = 32'h8;
      default: por_steps = 32'h10;
    endcase
  endfunction

  assign por_lim = 32'(POR_STEP) * por_steps({ctrl[twe_pkg::CTRL_PUP1],
                                              ctrl[twe_pkg::CTRL_PUP0]});

  // Hold reset output active until the delay runs out
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
    begin
      por_cnt   <= 32'h0;
      rst_out_n <= 1'b0;
    end
    else if (por_cnt < por_lim)
      por_cnt <= por_cnt + 32'h1;
    else
      rst_out_n <= 1'b1;
endmodule
`default_nettype wire

// File: logic/twe_pkg.sv
// Shared constants and types for the two-wire memory port
`default_nettype none
package twe_pkg;
  // Clock and timing
  localparam int CLK_HZ       = 50_000_000;
  localparam int WR_CYCLE_MS  = 5;
  localparam int WR_CYCLE_CYC = WR_CYCLE_MS * (CLK_HZ / 1000);
  localparam int POR_STEP_MS  = 50;
  localparam int POR_STEP_CYC = POR_STEP_MS * (CLK_HZ / 1000);
  localparam int HOST_QUARTER = 4;
  // Slave address type codes
  localparam logic [3:0] TYPE_MEM = 4'ha;
  localparam logic [3:0] TYPE_REG = 4'hb;
  // Register locations and reset values
  localparam logic [8:0] ADDR_CTRL   = 9'h1ff;
  localparam logic [8:0] ADDR_FAULT  = 9'h0ff;
  localparam logic [7:0] REG_WORD    = 8'hff;
  localparam logic [7:0] CTRL_RESET  = 8'h61;
  localparam logic [7:0] FAULT_RESET = 8'h00;
  // Control register field positions
  localparam int CTRL_WEL  = 1;
  localparam int CTRL_BP   = 4;
  localparam int CTRL_PUP1 = 7;
  localparam int CTRL_PUP0 = 0;
  // Array geometry and buffering
  localparam int MEM_BYTES  = 512;
  localparam int PAGE_BYTES = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int BYTE_W     = 8;
  // Device bus states and byte kinds
  typedef enum logic [2:0] {D_IDLE, D_RX, D_ACK, D_TX, D_MACK} twe_dst_t;
  typedef enum logic [1:0] {K_SLV, K_WORD, K_DATA} twe_kind_t;
  // Host states and transfer steps
  typedef enum logic [1:0] {H_IDLE, H_START, H_BYTE, H_STOP} twe_hst_t;
  typedef enum logic [2:0] {P_SLVW, P_WORD, P_WDATA, P_SLVR, P_RDATA} twe_step_t;
endpackage
`default_nettype wire

// File: logic/twe_bus_if.sv
// Two-wire bus carrier joining host and device ends
`default_nettype none
interface twe_bus_if;
  logic scl_h_out;
  logic scl_h_oe_n;
  logic sda_h_out;
  logic sda_h_oe_n;
  logic sda_d_out;
  logic sda_d_oe_n;
  logic scl;
  logic sda;

  // Wired-and of open-drain drivers with pull-up
  assign scl = ~(~scl_h_oe_n & ~scl_h_out);
  assign sda = ~((~sda_h_oe_n & ~sda_h_out) | (~sda_d_oe_n & ~sda_d_out));

  modport host (output scl_h_out, scl_h_oe_n, sda_h_out, sda_h_oe_n, input scl, sda);
  modport device (output sda_d_out, sda_d_oe_n, input scl, sda);
endinterface
`default_nettype wire

// File: logic/twe_host.sv
// Bus master end of the two-wire port with write data FIFO
`default_nettype none
module twe_fifo #(
  parameter int W = twe_pkg::BYTE_W,
  parameter int D = twe_pkg::FIFO_DEPTH
)(
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0]   cnt;

  assign in_ready  = cnt != (AW+1)'(D);
  assign out_valid = cnt != '0;
  assign out_data  = mem[rp];

  // Storage write
  always_ff @(posedge clk_sys)
    if (in_valid && in_ready)
      mem[wp] <= in_data;

  // Pointers and fill count
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
    begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end
    else
    begin
      if (in_valid && in_ready)
        wp <= (wp == AW'(D - 1)) ? '0 : wp + 1'b1;
      if (out_valid && out_ready)
        rp <= (rp == AW'(D - 1)) ? '0 : rp + 1'b1;
      cnt <= cnt + (AW+1)'(in_valid && in_ready) - (AW+1)'(out_valid && out_ready);
    end
endmodule

module twe_host #(
  parameter int QUARTER = twe_pkg::HOST_QUARTER
)(
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  twe_bus_if.host         bus,
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic       cmd_read,
  input  wire logic       cmd_reg,
  input  wire logic [8:0] cmd_addr,
  input  wire logic [7:0] cmd_len,
  input  wire logic       wr_valid,
  output logic            wr_ready,
  input  wire logic [7:0] wr_data,
  output logic [7:0]      rd_data,
  output logic            rd_valid,
  output logic            done,
  output logic            nacked
);
  // ****************************************
  // Data FIFO, sync and bit timing
  // ****************************************
  logic       f_valid;
  logic       f_pop;
  logic [7:0] f_data;

  twe_fifo #(.W(twe_pkg::BYTE_W), .D(twe_pkg::FIFO_DEPTH)) u_fifo (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   (wr_data),
    .out_valid (f_valid),
    .out_ready (f_pop),
    .out_data  (f_data)
  );

  logic [1:0] sda_y;
  logic [7:0] qcnt;
  logic       tick;

  // Two-flop sync of the data line, quarter-bit divider
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
    begin
      sda_y <= 2'h3;
      qcnt  <= 8'h00;
    end
    else
    begin
      sda_y <= {sda_y[0], bus.sda};
      qcnt  <= tick ? 8'h00 : qcnt + 8'h01;
    end

  assign tick = qcnt == 8'(QUARTER - 1);

  // Slave byte: type code, zeros, high bit, direction
  function automatic logic [7:0] slv(input logic r, input logic hi, input logic rd);
    slv = {r ? twe_pkg::TYPE_REG : twe_pkg::TYPE_MEM, 2'h0, hi, rd};
  endfunction

  // ****************************************
  // Transfer sequencer
  // ****************************************
  twe_pkg::twe_hst_t  st;
  twe_pkg::twe_step_t step;
  logic [1:0] ph;
  logic [3:0] bitn;
  logic [7:0] sh;
  logic [7:0] rx;
  logic [7:0] left;
  logic       c_read;
  logic       c_reg;
  logic [8:0] c_addr;
  logic       acked;
  logic       scl_oe_n;
  logic       sda_oe_n;
  logic       rxm;
  logic       be;
  logic       need;
  logic       stall;

  assign rxm   = step == twe_pkg::P_RDATA;
  assign be    = st == twe_pkg::H_BYTE && tick && ph == 2'h3 && bitn == 4'h8;
  assign need  = !rxm && acked && ((step == twe_pkg::P_WORD && !c_read)
                 || (step == twe_pkg::P_WDATA && left != 8'h01));
  assign stall = need && !f_valid;
  assign f_pop = be && need && f_valid;
  assign cmd_ready = st == twe_pkg::H_IDLE;

  assign bus.scl_h_out  = 1'b0;
  assign bus.sda_h_out  = 1'b0;
  assign bus.scl_h_oe_n = scl_oe_n;
  assign bus.sda_h_oe_n = sda_oe_n;

  // Symbol phases: start, byte with ninth bit, stop
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
    begin
      st       <= twe_pkg::H_IDLE;
      step     <= twe_pkg::P_SLVW;
      ph       <= 2'h0;
      bitn     <= 4'h0;
      sh       <= 8'h00;
      rx       <= 8'h00;
      left     <= 8'h00;
      c_read   <= 1'b0;
      c_reg    <= 1'b0;
      c_addr   <= 9'h000;
      acked    <= 1'b0;
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
      rd_data  <= 8'h00;
      rd_valid <= 1'b0;
      done     <= 1'b0;
      nacked   <= 1'b0;
    end
    else
    begin
      rd_valid <= 1'b0;
      done     <= 1'b0;
      if (st == twe_pkg::H_IDLE)
      begin
        if (cmd_valid)
        begin
          st     <= twe_pkg::H_START;
          step   <= twe_pkg::P_SLVW;
          ph     <= 2'h0;
          c_read <= cmd_read;
          c_reg  <= cmd_reg;
          c_addr <= cmd_addr;
          left   <= cmd_len;
          nacked <= 1'b0;
          sh     <= slv(cmd_reg, cmd_addr[8], 1'b0);
        end
      end
      else if (tick && !(be && stall))
      begin
        ph <= ph + 2'h1;
        case (st)
          twe_pkg::H_START:
            case (ph)
              2'h0: sda_oe_n <= 1'b1;
              2'h1: scl_oe_n <= 1'b1;
              2'h2: sda_oe_n <= 1'b0;
              default:
              begin
                scl_oe_n <= 1'b0;
                st       <= twe_pkg::H_BYTE;
                bitn     <= 4'h0;
              end
            endcase
          twe_pkg::H_BYTE:
            case (ph)
              2'h0:
                if (bitn == 4'h8)
                  sda_oe_n <= rxm ? left == 8'h01 : 1'b1;
                else
                  sda_oe_n <= rxm ? 1'b1 : sh[7];
              2'h1: scl_oe_n <= 1'b1;
              2'h2:
                if (bitn == 4'h8)
                  acked <= rxm | ~sda_y[1];
                else if (rxm)
                  rx <= {rx[6:0], sda_y[1]};
              default:
              begin
                scl_oe_n <= 1'b0;
                bitn     <= bitn + 4'h1;
                if (bitn != 4'h8)
                  sh <= {sh[6:0], 1'b0};
                else
                begin
                  bitn <= 4'h0;
                  if (!acked)
                  begin
                    nacked <= 1'b1;
                    st     <= twe_pkg::H_STOP;
                  end
                  else
                    case (step)
                      twe_pkg::P_SLVW:
                      begin
                        sh   <= c_addr[7:0];
                        step <= twe_pkg::P_WORD;
                      end
                      twe_pkg::P_WORD:
                        if (c_read)
                        begin
                          st   <= twe_pkg::H_START;
                          step <= twe_pkg::P_SLVR;
                          sh   <= slv(c_reg, c_addr[8], 1'b1);
                        end
                        else
                        begin
                          sh   <= f_data;
                          step <= twe_pkg::P_WDATA;
                        end
                      twe_pkg::P_WDATA:
                      begin
                        left <= left - 8'h01;
                        if (left == 8'h01)
                          st <= twe_pkg::H_STOP;
                        else
                          sh <= f_data;
                      end
                      twe_pkg::P_SLVR:
                        step <= twe_pkg::P_RDATA;
                      default:
                      begin
                        rd_data  <= rx;
                        rd_valid <= 1'b1;
                        left     <= left - 8'h01;
                        if (left == 8'h01)
                          st <= twe_pkg::H_STOP;
                      end
                    endcase
                end
              end
            endcase
          default:
            case (ph)
              2'h0: sda_oe_n <= 1'b0;
              2'h1: scl_oe_n <= 1'b1;
              2'h2: sda_oe_n <= 1'b1;
              default:
              begin
                st   <= twe_pkg::H_IDLE;
                done <= 1'b1;
              end
            endcase
        endcase
      end
    end
endmodule
`default_nettype wire

// File: tb/twe_assertions.sv
// Concurrent checks on the two-wire bus between host and device ends
`default_nettype none
module twe_checker (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic scl_h_out,
  input wire logic scl_h_oe_n,
  input wire logic sda_h_out,
  input wire logic sda_h_oe_n,
  input wire logic sda_d_out,
  input wire logic sda_d_oe_n,
  input wire logic scl,
  input wire logic sda
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Device pulls the data line
  sequence dev_pull;
    $fell(sda_d_oe_n);
  endsequence
  chk_scl_wired_level: assert property (scl == (scl_h_oe_n | scl_h_out))
    else $error("scl level differs from drivers");
  chk_sda_wired_level: assert property (
      sda == ((sda_h_oe_n | sda_h_out) & (sda_d_oe_n | sda_d_out)))
    else $error("sda level differs from drivers");
  chk_dev_open_drain: assert property (!sda_d_oe_n |-> !sda_d_out)
    else $error("device drives sda high");
  chk_dev_change_low: assert property ($changed(sda_d_oe_n) |-> !scl)
    else $error("device sda changed with scl high");
  chk_dev_stable_high: assert property (scl && $past(scl) |-> $stable(sda_d_oe_n))
    else $error("device sda moved during scl high");
  chk_dev_bit_hold: assert property (dev_pull |-> !sda_d_oe_n [*8])
    else $error("device bit too short");
  chk_dev_release: assert property (dev_pull |-> ##[1:200] sda_d_oe_n)
    else $error("device kept sda too long");
  chk_start_by_host: assert property (scl && $past(scl) && $fell(sda) |-> sda_d_oe_n)
    else $error("device made a start");
endmodule
`default_nettype wire

// File: tb/two_wire_eeprom_slave_port_bench.sv
// Bench joining host and device ends over the two-wire carrier
`default_nettype none
module two_wire_eeprom_slave_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, resetn = 0, wp = 0, cmd_valid = 0, cmd_read = 0, cmd_reg = 0;
  logic [8:0] cmd_addr = 0;
  logic [7:0] cmd_len = 1, wr_data = 0, rd_data, ctrl, fault;
  logic wr_valid = 0, cmd_ready, wr_ready, rd_valid, done, nacked, rst_out_n, busy;
  logic [7:0] rq[$];
  int failures = 0, samples_checked = 0, j;
  twe_bus_if bus ();
  twe_host twe_host_i (.clk_sys(clk_sys), .resetn(resetn), .bus(bus), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_reg(cmd_reg), .cmd_addr(cmd_addr),
    .cmd_len(cmd_len), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
    .rd_data(rd_data), .rd_valid(rd_valid), .done(done), .nacked(nacked));
  twe_device #(.WR_CYC(200), .POR_STEP(50)) twe_device_i (.clk_sys(clk_sys), .resetn(resetn),
    .bus(bus), .wp(wp), .rst_out_n(rst_out_n), .busy(busy), .ctrl(ctrl), .fault(fault));
  twe_checker twe_checker_i (.clk_sys(clk_sys), .resetn(resetn), .scl_h_out(bus.scl_h_out),
    .scl_h_oe_n(bus.scl_h_oe_n), .sda_h_out(bus.sda_h_out), .sda_h_oe_n(bus.sda_h_oe_n),
    .sda_d_out(bus.sda_d_out), .sda_d_oe_n(bus.sda_d_oe_n), .scl(bus.scl), .sda(bus.sda));
  // 50 MHz clock
  always #10 clk_sys = ~clk_sys;
  // Compare and count
  task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Verdict and stop
  task automatic end_sim();
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // One command, collecting read bytes until done
  task automatic run(input logic rd, input logic rg, input logic [8:0] a, input logic [7:0] n);
    int k;
    @(posedge clk_sys);
    #1;
    {cmd_valid, cmd_read, cmd_reg, cmd_addr, cmd_len} = {1'b1, rd, rg, a, n};
    @(posedge clk_sys);
    #1;
    cmd_valid = 0;
    rq.delete();
    for (k = 0; k < 20000 && done !== 1'b1; k++)
    begin
      @(posedge clk_sys);
      #1;
      if (rd_valid === 1'b1) rq.push_back(rd_data);
    end
    if (done !== 1'b1) failures++;
  endtask
  // Write command while the FIFO is filled beside it
  task automatic wr(input logic rg, input logic [8:0] a, input logic [7:0] n, input logic [7:0] b);
    fork
      run(0, rg, a, n);
      for (int i = 0; i < n; i++)
      begin
        @(posedge clk_sys);
        #1;
        wr_valid = 1;
        wr_data = b + 8'(i);
        while (wr_ready !== 1'b1)
        begin
          @(posedge clk_sys);
          #1;
        end
        @(posedge clk_sys);
        #1;
        wr_valid = 0;
      end
    join
  endtask
  // Let the write cycle finish
  task automatic idle();
    for (int k = 0; k < 1000 && busy !== 1'b0; k++) @(posedge clk_sys);
    if (busy !== 1'b0) failures++;
    repeat (4) @(posedge clk_sys);
  endtask
  // Watchdog
  initial
  begin
    #1200us;
    failures++;
    end_sim();
  end
  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk_sys);
    #1;
    resetn = 1;
    chk("ctrl_reset", ctrl, 8'h61);
    repeat (190) @(posedge clk_sys);
    chk("por_low", rst_out_n, 0);
    repeat (20) @(posedge clk_sys);
    chk("por_high", rst_out_n, 1);
    wr(0, 9'h010, 1, 8'h11);
    chk("wel_clear", nacked, 1);
    wr(1, 9'h1ff, 1, 8'h02);
    chk("ctrl", ctrl, 8'h02);
    wr(1, 9'h0ff, 1, 8'h5a);
    chk("fault", fault, 8'h5a);
    wr(1, 9'h0ff, 2, 8'h33);
    chk("reg_second", nacked, 1);
    chk("reg_kept", fault, 8'h5a);
    wr(0, 9'h01a, 18, 8'h30);
    chk("page_ack", nacked, 0);
    run(1, 0, 9'h01a, 1);
    chk("poll_busy", nacked, 1);
    idle();
    run(1, 0, 9'h010, 16);
    for (j = 0; j < 16; j++) chk("page", rq[j], (j < 12) ? 8'h36 + j : 8'h26 + j);
    wr(0, 9'h1ff, 1, 8'haa);
    idle();
    wr(0, 9'h000, 1, 8'h55);
    idle();
    run(1, 0, 9'h1ff, 2);
    chk("wrap", rq[1], 8'h55);
    chk("top", rq[0], 8'haa);
    run(1, 1, 9'h0ff, 1);
    chk("fault_read", rq[0], 8'h5a);
    wr(1, 9'h1ff, 1, 8'h12);
    wr(0, 9'h100, 1, 8'h77);
    chk("protect", nacked, 1);
    wp = 1;
    repeat (4) @(posedge clk_sys);
    wr(0, 9'h040, 1, 8'h00);
    chk("wp", nacked, 1);
    wr(1, 9'h1ff, 1, 8'h00);
    chk("wp_reg", nacked, 1);
    chk("wp_ctrl", ctrl, 8'h12);
    end_sim();
  end
endmodule
`default_nettype wire
